// [bcd_top.sv]
`timescale 1ns/10ps
`include "bcd_map.svh"
// Notes on behaviour
// RQ1 - Test battery at power-up and each day rollover while powered and oscillating.
// RQ2 - Battery-low flag, bit 4 of flags register, set when battery found low.
// RQ3 - Battery-low flag stays set until a later check passes.
// RQ4 - Battery checks happen only with main supply present, never on backup.
// RQ5 - Power-up clears steering, multiplier, resolution, alarm enables, access holds, test bit.
// RQ6 - After first power-up other control bits may be undefined.
// RQ7 - Later power-ups or reset leave other control bits unchanged.
// RQ8 - Power-down clears holds, test bit, watchdog; alarm enables keep their value.
// RQ9 - Watchdog register: steering on top, five-bit multiplier, two-bit resolution lowest.
// RQ10 - Alarm drives interrupt on backup only with both alarm enables set.
// RQ11 - Battery-low flag is read-only; writes and reads do not change it.
module bcd_top #(
    parameter int SETTLE_CYC = `BCD_SETTLE_CYC
) (
    // Clock and power-up reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Power and oscillator status.
    input wire logic main_power_ok,
    input wire logic osc_running,
    input wire logic power_down,
    input wire logic day_rollover,
    // Battery comparator.
    input wire logic batt_below,
    output logic batt_test_en,
    // Alarm flag from the alarm logic.
    input wire logic alarm_flag,
    // Parallel bus.
    input wire logic [12:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe,
    // Open-drain interrupt pin.
    output logic irq_o,
    output logic irq_oe,
    // Control bits for the rest of the device.
    output bcd_pkg::bcd_watchdog_t watchdog,
    output bcd_pkg::bcd_ctrl_t ctrl,
    output logic battery_low_flag
);
    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire bus_sel = ~ce_n & main_power_ok;
    wire bus_wr = bus_sel & ~we_n & ~power_down;
    wire hit_flags = (addr == `BCD_ADDR_FLAGS);
    wire hit_alarm = (addr == `BCD_ADDR_ALARM_EN);
    wire hit_wd = (addr == `BCD_ADDR_WATCHDOG);
    wire hit_ctl = (addr == `BCD_ADDR_CONTROL);
    wire hit_day = (addr == `BCD_ADDR_DAY);
    wire hit_any = hit_flags | hit_alarm | hit_wd | hit_ctl | hit_day;
    wire wr_alarm = bus_wr & hit_alarm;
    wire wr_wd = bus_wr & hit_wd;
    wire wr_ctl = bus_wr & hit_ctl;
    wire wr_day = bus_wr & hit_day;

    // ****************************************************************
    // Forced control bits.
    // ****************************************************************
    bcd_pkg::bcd_watchdog_t wd_ff;
    bcd_pkg::bcd_watchdog_t nxt_wd;
    bcd_pkg::bcd_ctrl_t ctl_ff;
    bcd_pkg::bcd_ctrl_t nxt_ctl;
    logic [5:0] cal_ff;
    logic [5:0] day_low_ff;

    always_comb begin
        nxt_wd = wd_ff;
        nxt_ctl = ctl_ff;
        if (wr_wd) begin
            nxt_wd = bcd_pkg::bcd_watchdog_t'(dq_i); // [RQ9]
        end
        if (wr_alarm) begin
            nxt_ctl.alarm_flag_enable = dq_i[`BCD_BIT_FLAG_EN];
            nxt_ctl.alarm_backup_enable = dq_i[`BCD_BIT_BACKUP_EN];
        end
        if (wr_ctl) begin
            nxt_ctl.write_hold = dq_i[`BCD_BIT_W];
            nxt_ctl.read_hold = dq_i[`BCD_BIT_R];
        end
        if (wr_day) begin
            nxt_ctl.frequency_test_enable = dq_i[`BCD_BIT_FREQ_TEST];
        end
        if (power_down) begin
            // Alarm enables are left as they were so a backup alarm can still wake the system.
            nxt_wd = bcd_pkg::bcd_watchdog_t'(`BCD_RST_WATCHDOG); // [RQ8]
            nxt_ctl.frequency_test_enable = `BCD_RST_BIT; // [RQ8]
            nxt_ctl.write_hold = `BCD_RST_BIT; // [RQ8]
            nxt_ctl.read_hold = `BCD_RST_BIT; // [RQ8]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wd_ff <= bcd_pkg::bcd_watchdog_t'(`BCD_RST_WATCHDOG); // [RQ5]
            ctl_ff <= '0; // [RQ5]
        end else begin
            wd_ff <= nxt_wd;
            ctl_ff <= nxt_ctl;
        end
    end

    // Other control bits have no reset so they survive power-up and reset.
    always_ff @(posedge ref_clk) begin
        if (wr_ctl) begin
            cal_ff <= dq_i[5:0]; // [RQ7] [RQ6]
        end
        if (wr_day) begin
            day_low_ff <= dq_i[5:0]; // [RQ7]
        end
    end

    // ****************************************************************
    // Battery check sequencer.
    // ****************************************************************
    bcd_pkg::bcd_state_t state_ff;
    bcd_pkg::bcd_state_t nxt_state;
    logic [15:0] cnt_ff;
    logic pend_ff;
    logic batt_low_ff;
    wire can_check = main_power_ok & osc_running;
    wire settle_done = (cnt_ff == 16'(SETTLE_CYC - 1));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bcd_pkg::BCD_IDLE: begin
                if (can_check & (pend_ff | day_rollover)) begin
                    nxt_state = bcd_pkg::BCD_SETTLE; // [RQ1]
                end
            end
            bcd_pkg::BCD_SETTLE: begin
                if (settle_done) begin
                    nxt_state = bcd_pkg::BCD_SAMPLE;
                end
            end
            bcd_pkg::BCD_SAMPLE: nxt_state = bcd_pkg::BCD_IDLE;
            default: nxt_state = bcd_pkg::BCD_IDLE;
        endcase
        if (!can_check) begin
            nxt_state = bcd_pkg::BCD_IDLE; // [RQ4]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= bcd_pkg::BCD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 16'h0000;
        end else if (state_ff == bcd_pkg::BCD_SETTLE) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end else begin
            cnt_ff <= 16'h0000;
        end
    end

    // The power-up check waits here until supply and oscillator are both good.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_ff <= 1'b1; // [RQ1]
        end else if (state_ff == bcd_pkg::BCD_SAMPLE) begin
            pend_ff <= 1'b0;
        end
    end

    // Only reset and a completed check change the flag; bus traffic never does.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            batt_low_ff <= 1'b0;
        end else if (state_ff == bcd_pkg::BCD_SAMPLE) begin
            batt_low_ff <= batt_below; // [RQ2] [RQ3] [RQ11]
        end
    end

    assign batt_test_en = (state_ff != bcd_pkg::BCD_IDLE) & can_check; // [RQ4]

    // ****************************************************************
    // Read data and pins.
    // ****************************************************************
    logic [7:0] rd_ff;
    wire [7:0] rd_mux = hit_flags ? {3'b000, batt_low_ff, 4'h0} :
                        hit_alarm ? {ctl_ff.alarm_flag_enable, ctl_ff.alarm_backup_enable, 6'h00} :
                        hit_wd ? wd_ff :
                        hit_ctl ? {ctl_ff.write_hold, ctl_ff.read_hold, cal_ff} :
                        hit_day ? {1'b0, ctl_ff.frequency_test_enable, day_low_ff} : 8'h00;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ff <= 8'h00;
        end else begin
            rd_ff <= rd_mux;
        end
    end

    assign dq_o = rd_ff;
    assign dq_oe = bus_sel & ~oe_n & we_n & hit_any;
    assign irq_o = 1'b0;
    assign irq_oe = alarm_flag & ctl_ff.alarm_flag_enable
                  & (main_power_ok | ctl_ff.alarm_backup_enable); // [RQ10]
    assign watchdog = wd_ff;
    assign ctrl = ctl_ff;
    assign battery_low_flag = batt_low_ff;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_low_set;
        @(posedge ref_clk) disable iff (rst)
        (state_ff == bcd_pkg::BCD_SAMPLE) && batt_below |=> batt_low_ff;
    endproperty
    a_low_set: assert property (p_low_set) else $error("battery low not flagged"); // [RQ2]

    property p_low_pass;
        @(posedge ref_clk) disable iff (rst)
        (state_ff == bcd_pkg::BCD_SAMPLE) && !batt_below |=> !batt_low_ff;
    endproperty
    a_low_pass: assert property (p_low_pass) else $error("passing check left flag set"); // [RQ3]

    property p_low_hold;
        @(posedge ref_clk) disable iff (rst)
        (state_ff != bcd_pkg::BCD_SAMPLE) |=> $stable(batt_low_ff);
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("flag changed without a check"); // [RQ11]

    property p_backup_idle;
        @(posedge ref_clk) disable iff (rst)
        !main_power_ok |-> !batt_test_en ##1 (state_ff == bcd_pkg::BCD_IDLE);
    endproperty
    a_backup_idle: assert property (p_backup_idle) else $error("check ran on backup"); // [RQ4]

    property p_rollover;
        @(posedge ref_clk) disable iff (rst)
        (state_ff == bcd_pkg::BCD_IDLE) && day_rollover && can_check
        |=> (state_ff == bcd_pkg::BCD_SETTLE) ##[1:40] (state_ff == bcd_pkg::BCD_SAMPLE) || !can_check;
    endproperty
    a_rollover: assert property (p_rollover) else $error("rollover check not run"); // [RQ1]

    property p_pd_clear;
        @(posedge ref_clk) disable iff (rst)
        power_down |=> (wd_ff == 8'h00) && !ctl_ff.frequency_test_enable && !ctl_ff.write_hold && !ctl_ff.read_hold;
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("power-down did not clear bits"); // [RQ8]

    property p_pd_keep;
        @(posedge ref_clk) disable iff (rst)
        power_down && !wr_alarm |=> $stable(ctl_ff.alarm_flag_enable) && $stable(ctl_ff.alarm_backup_enable);
    endproperty
    a_pd_keep: assert property (p_pd_keep) else $error("power-down lost alarm enables"); // [RQ8]

    property p_wd_layout;
        @(posedge ref_clk) disable iff (rst)
        wr_wd && !power_down |=> watchdog.watchdog_steering == $past(dq_i[7])
            && watchdog.timeout_multiplier == $past(dq_i[6:2]) && watchdog.timeout_resolution == $past(dq_i[1:0]);
    endproperty
    a_wd_layout: assert property (p_wd_layout) else $error("watchdog fields misplaced"); // [RQ9]

    property p_irq_backup;
        @(posedge ref_clk) disable iff (rst)
        irq_oe && !main_power_ok |-> ctl_ff.alarm_backup_enable && ctl_ff.alarm_flag_enable && alarm_flag;
    endproperty
    a_irq_backup: assert property (p_irq_backup) else $error("backup interrupt without enables"); // [RQ10]
endmodule

// [bcd_map.svh]
`ifndef BCD_MAP_SVH
`define BCD_MAP_SVH
// ****************************************************************
// Register addresses on the parallel bus.
// ****************************************************************
`define BCD_ADDR_FLAGS 13'h1ff0
`define BCD_ADDR_ALARM_EN 13'h1ff6
`define BCD_ADDR_WATCHDOG 13'h1ff7
`define BCD_ADDR_CONTROL 13'h1ff8
`define BCD_ADDR_DAY 13'h1ffc
// ****************************************************************
// Field positions.
// ****************************************************************
`define BCD_BIT_BATT_LOW 4
`define BCD_BIT_FLAG_EN 7
`define BCD_BIT_BACKUP_EN 6
`define BCD_BIT_FREQ_TEST 6
`define BCD_BIT_W 7
`define BCD_BIT_R 6
// ****************************************************************
// Reset values.
// ****************************************************************
`define BCD_RST_WATCHDOG 8'h00
`define BCD_RST_BIT 1'b0
// ****************************************************************
// Timing.
// ****************************************************************
`define BCD_CLK_MHZ 20
`define BCD_SETTLE_NS 1000
`define BCD_SETTLE_CYC ((`BCD_SETTLE_NS * `BCD_CLK_MHZ + 999) / 1000)
`endif

// [bcd_pkg.sv]
package bcd_pkg;
    // Watchdog register layout, top bit first.
    typedef struct packed {
        logic       watchdog_steering;
        logic [4:0] timeout_multiplier;
        logic [1:0] timeout_resolution;
    } bcd_watchdog_t;

    // Bits that the power transitions force.
    typedef struct packed {
        logic alarm_flag_enable;
        logic alarm_backup_enable;
        logic frequency_test_enable;
        logic write_hold;
        logic read_hold;
    } bcd_ctrl_t;

    typedef enum logic [2:0] {
        BCD_IDLE   = 3'b001,
        BCD_SETTLE = 3'b010,
        BCD_SAMPLE = 3'b100
    } bcd_state_t;
endpackage

// [bcd_host.sv]
`timescale 1ns/10ps
// ****************************************************************
// Host processor model on the parallel bus.
// ****************************************************************
module bcd_host (
    // Clock.
    input wire logic ref_clk,
    // Bus towards the device.
    output logic [12:0] addr,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [7:0] dq_i,
    input wire logic [7:0] dq_o,
    input wire logic dq_oe
);
    initial begin
        addr = 13'h0000;
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        dq_i = 8'h00;
    end

    // Released write data shows the inverse so a stale value is never mistaken.
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        addr = a;
        dq_i = d;
        ce_n = 1'b0;
        we_n = 1'b0;
        @(negedge ref_clk);
        ce_n = 1'b1;
        we_n = 1'b1;
        dq_i = ~d;
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe);
        @(negedge ref_clk);
        addr = a;
        ce_n = 1'b0;
        oe_n = 1'b0;
        @(negedge ref_clk);
        d = dq_o;
        oe = dq_oe;
        ce_n = 1'b1;
        oe_n = 1'b1;
    endtask
endmodule

// [battery_check_and_defaults_test.sv]
`timescale 1ns/10ps
module battery_check_and_defaults_test;
    typedef struct packed {
        logic [12:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic oe;
    } bcd_row_t;
    localparam int SETTLE = 2;
    logic ref_clk, rst, main_power_ok, osc_running, power_down, day_rollover, batt_below, alarm_flag;
    logic [12:0] addr;
    logic ce_n, oe_n, we_n, dq_oe, batt_test_en, irq_o, irq_oe, battery_low_flag, roe;
    logic [7:0] dq_i, dq_o, rdat;
    bcd_pkg::bcd_watchdog_t watchdog;
    bcd_pkg::bcd_ctrl_t ctrl;
    int mismatches = 0;
    int samples_checked = 0;
    bcd_row_t rows [5] = '{'{13'h1ff6, 8'hc0, 8'hc0, 1'b1}, '{13'h1ffc, 8'h45, 8'h45, 1'b1},
        '{13'h1ff8, 8'hc5, 8'hc5, 1'b1}, '{13'h1ff1, 8'h55, 8'h00, 1'b0}, '{13'h1ff7, 8'h0e, 8'h0e, 1'b1}};

    bcd_top #(.SETTLE_CYC(SETTLE)) DUT (.ref_clk(ref_clk), .rst(rst), .main_power_ok(main_power_ok),
        .osc_running(osc_running), .power_down(power_down), .day_rollover(day_rollover),
        .batt_below(batt_below), .batt_test_en(batt_test_en), .alarm_flag(alarm_flag), .addr(addr),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .irq_o(irq_o),
        .irq_oe(irq_oe), .watchdog(watchdog), .ctrl(ctrl), .battery_low_flag(battery_low_flag));

    bcd_host host (.ref_clk(ref_clk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe(dq_oe));

    // ****************************************************************
    // Checking and closing.
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e, input logic oe);
        host.rd(a, rdat, roe);
        chk(rdat, e, "read data");
        chk({7'h00, roe}, {7'h00, oe}, "read enable");
    endtask

    // A rollover pulse; the check must either start at once or not at all.
    task automatic day_check(input logic run);
        day_rollover = 1'b1;
        @(negedge ref_clk);
        day_rollover = 1'b0;
        @(negedge ref_clk);
        chk({7'h00, batt_test_en}, {7'h00, run}, "check running");
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        #100_000;
        mismatches++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        rst = 1'b1;
        main_power_ok = 1'b1;
        osc_running = 1'b1;
        power_down = 1'b0;
        day_rollover = 1'b0;
        batt_below = 1'b1;
        alarm_flag = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(watchdog, 8'h00, "reset watchdog");
        chk({3'b000, ctrl}, 8'h00, "reset ctrl");
        rst = 1'b0;
        repeat (SETTLE + 4) @(negedge ref_clk);
        chk({7'h00, battery_low_flag}, 8'h01, "power-up check");
        rd_chk(13'h1ff0, 8'h10, 1'b1);
        rd_chk(13'h1ff0, 8'h10, 1'b1);
        host.wr(13'h1ff0, 8'h00);
        rd_chk(13'h1ff0, 8'h10, 1'b1);
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e, rows[i].oe);
        end
        chk({watchdog.watchdog_steering, 2'b00, watchdog.timeout_multiplier}, 8'h03, "multiplier");
        chk({6'h00, watchdog.timeout_resolution}, 8'h02, "resolution");
        chk({3'b000, ctrl}, 8'h1f, "ctrl set");
        host.wr(13'h1ff7, 8'h8e);
        main_power_ok = 1'b0;
        power_down = 1'b1;
        @(negedge ref_clk);
        power_down = 1'b0;
        @(negedge ref_clk);
        chk(watchdog, 8'h00, "power-down watchdog");
        chk({3'b000, ctrl}, 8'h18, "power-down ctrl");
        alarm_flag = 1'b1;
        #1 chk({7'h00, irq_oe}, 8'h01, "backup alarm");
        chk({7'h00, irq_o}, 8'h00, "open-drain level");
        host.wr(13'h1ff7, 8'hff);
        chk(watchdog, 8'h00, "backup write refused");
        day_check(1'b0);
        main_power_ok = 1'b1;
        host.wr(13'h1ff6, 8'h80);
        main_power_ok = 1'b0;
        #1 chk({7'h00, irq_oe}, 8'h00, "backup alarm masked");
        @(negedge ref_clk);
        main_power_ok = 1'b1;
        #1 chk({7'h00, irq_oe}, 8'h01, "powered alarm");
        @(negedge ref_clk);
        alarm_flag = 1'b0;
        batt_below = 1'b0;
        day_check(1'b1);
        chk({7'h00, battery_low_flag}, 8'h00, "flag cleared");
        batt_below = 1'b1;
        osc_running = 1'b0;
        day_check(1'b0);
        chk({7'h00, battery_low_flag}, 8'h00, "no check without oscillator");
        osc_running = 1'b1;
        day_check(1'b1);
        chk({7'h00, battery_low_flag}, 8'h01, "flag set");
        host.wr(13'h1ff6, 8'hc0);
        host.wr(13'h1ff7, 8'h0e);
        @(negedge ref_clk);
        rst = 1'b1;
        @(negedge ref_clk);
        chk(watchdog, 8'h00, "second reset watchdog");
        chk({3'b000, ctrl}, 8'h00, "second reset ctrl");
        rst = 1'b0;
        rd_chk(13'h1ff8, 8'h05, 1'b1);
        rd_chk(13'h1ffc, 8'h05, 1'b1);
        repeat (SETTLE + 4) @(negedge ref_clk);
        chk({7'h00, battery_low_flag}, 8'h01, "second power-up check");
        print_verdict();
    end
endmodule
